// ### common/pced_defs.vh
`ifndef PCED_DEFS_VH
`define PCED_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PCED_ADDR_PA_RISE   12'h000
`define PCED_ADDR_PA_FALL   12'h004
`define PCED_ADDR_PA_FLAG   12'h008
`define PCED_ADDR_PB_RISE   12'h00c
`define PCED_ADDR_PB_FALL   12'h010
`define PCED_ADDR_PB_FLAG   12'h014
`define PCED_ADDR_PC_RISE   12'h018
`define PCED_ADDR_PC_FALL   12'h01c
`define PCED_ADDR_PC_FLAG   12'h020
`define PCED_ADDR_IRQ_CTRL  12'h024
`define PCED_ADDR_IRQ_STAT  12'h028

// ----------------------------------------------------------------
// Implemented bit masks
// ----------------------------------------------------------------
`define PCED_MASK_PA        8'h3f
`define PCED_MASK_PB        8'hf0
`define PCED_MASK_PC_BIG    8'hff
`define PCED_MASK_PC_SMALL  8'h3f
`define PCED_MASK_NONE      8'h00

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PCED_BIT_IRQ_EN     0
`define PCED_BIT_SUM_FLAG   0
`define PCED_RST_REG        8'h00

`endif

// ### src/pced_sync.v
`default_nettype none

// ----------------------------------------------------------------
// Three-stage pin synchroniser, change taken when stages 2 and 3 agree
// ----------------------------------------------------------------
module pced_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] pin_i,
    output reg  [WIDTH-1:0] level_o
);
    reg [WIDTH-1:0] s1_ff;
    reg [WIDTH-1:0] s2_ff;
    reg [WIDTH-1:0] s3_ff;

    // Stage 1 feeds only stage 2, so metastability stays contained
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_ff   <= {WIDTH{1'b0}};
            s2_ff   <= {WIDTH{1'b0}};
            s3_ff   <= {WIDTH{1'b0}};
            level_o <= {WIDTH{1'b0}};
        end else begin
            s1_ff   <= pin_i;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            level_o <= (s2_ff & s3_ff) | (~(s2_ff ^ s3_ff) & s3_ff) | (level_o & (s2_ff ^ s3_ff));
        end
    end
endmodule // pced_sync

`default_nettype wire

// ### src/pced_port.v
`default_nettype none

// ----------------------------------------------------------------
// One port: enables, edge detection and sticky change flags
// ----------------------------------------------------------------
module pced_port #(
    parameter [7:0] IMPL = 8'hff
) (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire [7:0] level_i,
    input  wire       wr_rise_i,
    input  wire       wr_fall_i,
    input  wire       wr_flag_i,
    input  wire [7:0] wdata_i,
    output reg  [7:0] rise_en_o,
    output reg  [7:0] fall_en_o,
    output reg  [7:0] flags_o,
    output wire [7:0] hit_o
);
    reg  [7:0] prev_ff;
    wire [7:0] rose = level_i & ~prev_ff;
    wire [7:0] fell = ~level_i & prev_ff;

    // Disabled direction produces no hit; absent bits never hit
    assign hit_o = ((rose & rise_en_o) | (fell & fall_en_o)) & IMPL;

    // Writes to absent bits are dropped so they read as zero
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_ff   <= 8'h00;
            rise_en_o <= 8'h00;
            fall_en_o <= 8'h00;
            flags_o   <= 8'h00;
        end else begin
            prev_ff <= level_i;
            if (wr_rise_i) begin
                rise_en_o <= wdata_i & IMPL;
            end
            if (wr_fall_i) begin
                fall_en_o <= wdata_i & IMPL;
            end
            // Software writes 0 to clear; a new hit in the same cycle wins
            if (wr_flag_i) begin
                flags_o <= ((flags_o & wdata_i) | hit_o) & IMPL;
            end else begin
                flags_o <= flags_o | hit_o;
            end
        end
    end
endmodule // pced_port

`default_nettype wire

// ### src/pced_top.v
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "pced_defs.vh"
`default_nettype none

module pced_top #(
    parameter LARGE = 1
) (
    input  wire        CLK_SYS_I,
    input  wire        RST_N_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    input  wire [7:0]  PORTA_PIN_I,
    input  wire [7:0]  PORTB_PIN_I,
    input  wire [7:0]  PORTC_PIN_N_I,
    output reg         IRQ_O
);
    // ----------------------------------------------------------------
    // Variant masks
    // ----------------------------------------------------------------
    localparam [7:0] MASK_A = `PCED_MASK_PA;
    localparam [7:0] MASK_B = LARGE ? `PCED_MASK_PB : `PCED_MASK_NONE;
    localparam [7:0] MASK_C = LARGE ? `PCED_MASK_PC_BIG : `PCED_MASK_PC_SMALL;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Only the access phase answers; pready is a register so it is one wait
    wire       access  = PSEL_I & PENABLE_I & ~PREADY_O;
    wire       wr      = access & PWRITE_I;
    wire [7:0] wd      = PWDATA_I[7:0];

    // Address match reused by every write strobe
    function hit_addr;
        input [11:0] a;
        input [11:0] ref_a;
        begin
            hit_addr = (a == ref_a);
        end
    endfunction

    wire [7:0] lvl_a;
    wire [7:0] lvl_b;
    wire [7:0] lvl_c;
    wire [7:0] ra, fa, ga, ha;
    wire [7:0] rb, fb, gb, hb;
    wire [7:0] rc, fc, gc, hc;

    reg  sum_flag_ff;
    reg  irq_en_ff;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pced_sync #(.WIDTH(24)) u_sync (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .pin_i   ({PORTC_PIN_N_I, PORTB_PIN_I, PORTA_PIN_I}),
        .level_o ({lvl_c, lvl_b, lvl_a})
    );

    // ----------------------------------------------------------------
    // Ports
    // ----------------------------------------------------------------
    pced_port #(.IMPL(MASK_A)) u_pa (
        .clk_i     (CLK_SYS_I),
        .rst_n_i   (RST_N_I),
        .level_i   (lvl_a),
        .wr_rise_i (wr & hit_addr(PADDR_I, `PCED_ADDR_PA_RISE)),
        .wr_fall_i (wr & hit_addr(PADDR_I, `PCED_ADDR_PA_FALL)),
        .wr_flag_i (wr & hit_addr(PADDR_I, `PCED_ADDR_PA_FLAG)),
        .wdata_i   (wd),
        .rise_en_o (ra),
        .fall_en_o (fa),
        .flags_o   (ga),
        .hit_o     (ha)
    );

    pced_port #(.IMPL(MASK_B)) u_pb (
        .clk_i     (CLK_SYS_I),
        .rst_n_i   (RST_N_I),
        .level_i   (lvl_b),
        .wr_rise_i (wr & hit_addr(PADDR_I, `PCED_ADDR_PB_RISE)),
        .wr_fall_i (wr & hit_addr(PADDR_I, `PCED_ADDR_PB_FALL)),
        .wr_flag_i (wr & hit_addr(PADDR_I, `PCED_ADDR_PB_FLAG)),
        .wdata_i   (wd),
        .rise_en_o (rb),
        .fall_en_o (fb),
        .flags_o   (gb),
        .hit_o     (hb)
    );

    pced_port #(.IMPL(MASK_C)) u_pc (
        .clk_i     (CLK_SYS_I),
        .rst_n_i   (RST_N_I),
        .level_i   (lvl_c),
        .wr_rise_i (wr & hit_addr(PADDR_I, `PCED_ADDR_PC_RISE)),
        .wr_fall_i (wr & hit_addr(PADDR_I, `PCED_ADDR_PC_FALL)),
        .wr_flag_i (wr & hit_addr(PADDR_I, `PCED_ADDR_PC_FLAG)),
        .wdata_i   (wd),
        .rise_en_o (rc),
        .fall_en_o (fc),
        .flags_o   (gc),
        .hit_o     (hc)
    );

    // ----------------------------------------------------------------
    // Summary flag and interrupt
    // ----------------------------------------------------------------
    wire any_hit = |{ha, hb, hc};
    wire sum_clr = wr & hit_addr(PADDR_I, `PCED_ADDR_IRQ_STAT) & wd[`PCED_BIT_SUM_FLAG];

    // Write-one-to-clear; an edge in the same cycle keeps the flag set
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sum_flag_ff <= 1'b0;
            irq_en_ff   <= 1'b0;
            IRQ_O       <= 1'b0;
        end else begin
            if (any_hit) begin
                sum_flag_ff <= 1'b1;
            end else if (sum_clr) begin
                sum_flag_ff <= 1'b0;
            end
            if (wr & hit_addr(PADDR_I, `PCED_ADDR_IRQ_CTRL)) begin
                irq_en_ff <= wd[`PCED_BIT_IRQ_EN];
            end
            IRQ_O <= sum_flag_ff & irq_en_ff;
        end
    end

    // ----------------------------------------------------------------
    // Read mux and bus answer
    // ----------------------------------------------------------------
    reg [7:0] rd_byte;
    reg       rd_ok;

    // Unmapped addresses read zero and flag a slave error
    always @* begin
        rd_byte = 8'h00;
        rd_ok   = 1'b1;
        case (PADDR_I)
            `PCED_ADDR_PA_RISE:  rd_byte = ra;
            `PCED_ADDR_PA_FALL:  rd_byte = fa;
            `PCED_ADDR_PA_FLAG:  rd_byte = ga;
            `PCED_ADDR_PB_RISE:  rd_byte = rb;
            `PCED_ADDR_PB_FALL:  rd_byte = fb;
            `PCED_ADDR_PB_FLAG:  rd_byte = gb;
            `PCED_ADDR_PC_RISE:  rd_byte = rc;
            `PCED_ADDR_PC_FALL:  rd_byte = fc;
            `PCED_ADDR_PC_FLAG:  rd_byte = gc;
            `PCED_ADDR_IRQ_CTRL: rd_byte = {7'h00, irq_en_ff};
            `PCED_ADDR_IRQ_STAT: rd_byte = {7'h00, sum_flag_ff};
            default:             rd_ok   = 1'b0;
        endcase
    end

    // One wait state: pready rises one cycle into the access phase
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
        end else begin
            PREADY_O  <= access;
            PSLVERR_O <= access & ~rd_ok;
            if (access & ~PWRITE_I) begin
                PRDATA_O <= {24'h00_0000, rd_byte};
            end
        end
    end
endmodule // pced_top

`default_nettype wire

// ### test/pced_pin_model.sv
`default_nettype none
module pced_pin_model (
    input  wire logic        clk_i,
    input  wire logic [23:0] level_i,
    output var  logic [23:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins move only after an edge, never mid-cycle; one process drives them
    always @(posedge clk_i) begin
        pins_o <= level_i;
    end
endmodule // pced_pin_model
`default_nettype wire

// ### test/pced_top_monitor.sv
`default_nettype none
module pced_top_monitor (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_N_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    // Bus answers after exactly one wait state and only for one cycle
    property p_wait; PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_pulse; PREADY_O |=> !PREADY_O; endproperty
    a_pulse: assert property (p_pulse) else $error("ready stuck");
    property p_cause; PREADY_O |-> $past(PSEL_I && PENABLE_I); endproperty
    a_cause: assert property (p_cause) else $error("ready unasked");
    property p_err; PREADY_O && PADDR_I[1:0] == 2'b00 |-> PSLVERR_O == (PADDR_I > 12'h028); endproperty
    a_err: assert property (p_err) else $error("slverr wrong");
    property p_upper; PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h000000 && (!PSLVERR_O || PRDATA_O == 32'h0); endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits");
    property p_pa; PREADY_O && !PWRITE_I && PADDR_I <= 12'h008 |-> PRDATA_O[7:6] == 2'b00; endproperty
    a_pa: assert property (p_pa) else $error("port a bits 7:6 set");
    property p_pb; PREADY_O && !PWRITE_I && PADDR_I inside {12'h00c, 12'h010, 12'h014} |-> PRDATA_O[3:0] == 4'h0; endproperty
    a_pb: assert property (p_pb) else $error("port b bits 3:0 set");
    property p_rst; disable iff (1'b0) !RST_N_I |-> !IRQ_O && !PREADY_O && !PSLVERR_O; endproperty
    a_rst: assert property (p_rst) else $error("outputs live in reset");
endmodule // pced_top_monitor
bind pced_top pced_top_monitor i_pced_top_monitor (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ### test/tb_pin_change_edge_detector.sv
`default_nettype none
module tb_pin_change_edge_detector;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] MSK = 24'hfff03f;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [23:0] lvl = 0, pins;
    logic [7:0]  expq[$], e;
    int err_total = 0, total_checks = 0, seed = 32'heb0e;
    pced_top #(.LARGE(1)) i_pced_top (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PORTA_PIN_I(pins[7:0]), .PORTB_PIN_I(pins[15:8]), .PORTC_PIN_N_I(pins[23:16]),
        .IRQ_O(irq));
    pced_pin_model i_pced_pin_model (.clk_i(clk), .level_i(lvl), .pins_o(pins));
    initial forever #5 clk = ~clk;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    // Read notes its expected byte; request held until ready is seen, only the watchdog ends a wait
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        if (!w) expq.push_back(d);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task do_reset;
        rst_n <= 0;
        repeat (12) @(posedge clk);
        rst_n <= 1;
    endtask
    // Program all ports, then a rise and a fall on a random set of pins, always including pin 0 of each port
    task edges(input logic [7:0] re, input logic [7:0] fe);
        logic [23:0] v;
        v = 24'($random(seed)) | 24'h010101;
        for (int p = 0; p < 3; p++) begin
            apb(1, 12'(12 * p), re);
            apb(1, 12'(12 * p + 4), fe);
            apb(0, 12'(12 * p), re & MSK[8*p+:8]);
            apb(0, 12'(12 * p + 4), fe & MSK[8*p+:8]);
        end
        lvl <= v;
        repeat (8) @(posedge clk);
        for (int p = 0; p < 3; p++) apb(0, 12'(12 * p + 8), v[8*p+:8] & MSK[8*p+:8] & re);
        // Clear first, so a disabled falling edge cannot hide behind a rise flag
        for (int p = 0; p < 3; p++) apb(1, 12'(12 * p + 8), 8'h00);
        lvl <= 24'h000000;
        repeat (8) @(posedge clk);
        for (int p = 0; p < 3; p++) apb(0, 12'(12 * p + 8), v[8*p+:8] & MSK[8*p+:8] & fe);
        apb(0, 12'h028, 8'h01);
        for (int p = 0; p < 3; p++) begin
            apb(1, 12'(12 * p + 8), 8'h00);
            apb(0, 12'(12 * p + 8), 8'h00);
        end
    endtask
    // Every read answer is matched against the oldest note
    always @(posedge clk) begin
        if (pready === 1'b1 && psel && !pwrite) begin
            e = expq.size() ? expq.pop_front() : 8'hxx;
            cmp("read data", {24'h0, e}, prdata);
        end
        // Of the word-aligned offsets, only those past the status register are unmapped
        if (pready === 1'b1 && psel === 1'b1) begin
            cmp("slave error", {31'h0, paddr > 12'h028}, {31'h0, pslverr});
        end
    end
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #200us;
        err_total++;
        summarize;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset;
        for (int i = 0; i < 11; i++) apb(0, 12'(4 * i), 8'h00);
        $display("reset values done");
        edges(8'hff, 8'h00);
        cmp("irq masked", 32'h0, {31'h0, irq});
        apb(1, 12'h024, 8'h01);
        repeat (3) @(posedge clk);
        cmp("irq raised", 32'h1, {31'h0, irq});
        apb(1, 12'h028, 8'h01);
        repeat (3) @(posedge clk);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        apb(0, 12'h028, 8'h00);
        $display("rising edges done");
        edges(8'h00, 8'hff);
        apb(0, 12'h02c, 8'h00);
        $display("falling edges done");
        lvl <= 24'hffffff;
        repeat (8) @(posedge clk);
        do_reset;
        lvl <= 24'h000000;
        cmp("irq after reset", 32'h0, {31'h0, irq});
        for (int i = 0; i < 11; i++) apb(0, 12'(4 * i), 8'h00);
        repeat (4) @(posedge clk);
        $display("second reset done");
        summarize;
    end
endmodule // tb_pin_change_edge_detector
`default_nettype wire
